/* File: src/swrs_map.svh */
// constants for the supply watchdog reset supervisor
//
// Contract
// - reset is asserted whenever the supply code is below the trip register.
// - reset stays asserted 100 ms after the supply climbs back above trip.
// - watchdog period is set in 100 ms steps from 100 ms to 3 s.
// - an enabled watchdog not restarted in time gives 100 ms of reset.
// - a flag records which source started the latest reset.
// - a manual reset is accepted only after a stable low filter time.
// - the reset line is active low for supply, watchdog and manual causes.
// - the line is only pulled low by the device, else left to the pull-up.
// - an outside low on the same line is sensed as a manual reset request.
`ifndef SWRS_MAP_SVH
`define SWRS_MAP_SVH

// register word offsets
`define SWRS_REG_CTRL 8'h00
`define SWRS_REG_PERIOD 8'h01
`define SWRS_REG_TRIP 8'h02
`define SWRS_REG_KICK 8'h03
`define SWRS_REG_STATUS 8'h04
`define SWRS_REG_CLEAR 8'h05
`define SWRS_REG_IRQ_EN 8'h06

// field positions
`define SWRS_CTRL_WDT_EN 0
`define SWRS_EV_LV 0
`define SWRS_EV_WDT 1
`define SWRS_EV_MR 2
`define SWRS_ST_LAST_LO 4
`define SWRS_ST_LINE 7

// reset values and period limits
`define SWRS_TRIP_RST 8'h80
`define SWRS_PERIOD_RST 5'h0A
`define SWRS_PERIOD_MIN 5'h01
`define SWRS_PERIOD_MAX 5'h1E

// timing, clock in kHz
`define SWRS_CLK_KHZ 100000
`define SWRS_HOLD_MS 100
`define SWRS_TICK_MS 100
`define SWRS_MR_FILT_MS 1
`define SWRS_HOLD_CYC (`SWRS_HOLD_MS * `SWRS_CLK_KHZ)
`define SWRS_TICK_CYC (`SWRS_TICK_MS * `SWRS_CLK_KHZ)
`define SWRS_MR_FILT_CYC (`SWRS_MR_FILT_MS * `SWRS_CLK_KHZ)

`endif

/* File: src/swrs_pkg.sv */
// types for the supply watchdog reset supervisor
package swrs_pkg;
	typedef enum logic [1:0] {
		SWRS_RUN = 2'b01,
		SWRS_HOLD = 2'b10
	} swrs_state_t;
	typedef enum logic [1:0] {
		SWRS_SRC_NONE = 2'h0,
		SWRS_SRC_LV = 2'h1,
		SWRS_SRC_WDT = 2'h2,
		SWRS_SRC_MR = 2'h3
	} swrs_src_t;
endpackage : swrs_pkg

/* File: src/swrs_top.sv */
// supply, watchdog and manual reset supervisor with register port
`timescale 1ns/10ps
`include "swrs_map.svh"

module swrs_top import swrs_pkg::*; #(
	parameter int HOLD_CYC = `SWRS_HOLD_CYC,
	parameter int TICK_CYC = `SWRS_TICK_CYC,
	parameter int MR_FILT_CYC = `SWRS_MR_FILT_CYC
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] supply_code_in,
	input wire logic rst_line_in,
	output logic rst_line_out,
	output logic rst_line_oe_n_out,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic irq_out
);

	localparam logic [23:0] HOLD_LAST = 24'(HOLD_CYC - 1);
	localparam logic [23:0] TICK_LAST = 24'(TICK_CYC - 1);
	localparam logic [23:0] FILT_LAST = 24'(MR_FILT_CYC - 1);

	// register group state
	logic wdt_en_q, wdt_en_d;
	logic [4:0] period_q, period_d;
	logic [7:0] trip_q, trip_d;
	logic [2:0] status_q, status_d;
	logic [2:0] irq_en_q, irq_en_d;
	swrs_src_t last_q, last_d;
	logic [7:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic kick;

	// supervisor state
	swrs_state_t state_q, state_d;
	logic [23:0] hold_q, hold_d;
	logic drive_q, drive_d;
	logic low_q, low_d;
	logic supply_low;

	// watchdog state
	logic [23:0] pre_q, pre_d;
	logic [4:0] tick_q, tick_d;
	logic wdt_fire;

	// manual reset filter state
	logic [23:0] filt_q, filt_d;
	logic armed_q, armed_d;
	logic mr_fire;

	// events of this cycle
	logic [2:0] ev;

	// supply compare against the programmed trip point
	assign supply_low = (supply_code_in < trip_q);
	assign kick = reg_wr_in && (reg_addr_in == `SWRS_REG_KICK);

	// register next values
	always_comb begin
		wdt_en_d = wdt_en_q;
		period_d = period_q;
		trip_d = trip_q;
		irq_en_d = irq_en_q;
		last_d = last_q;
		rdata_d = 8'h00;
		status_d = status_q;
		if (reg_wr_in) begin
			if (reg_addr_in == `SWRS_REG_CTRL) begin
				wdt_en_d = reg_wdata_in[`SWRS_CTRL_WDT_EN];
			end else if (reg_addr_in == `SWRS_REG_PERIOD) begin
				// out of range steps clamp to 100 ms .. 3 s
				// the upper bound is tested on the full byte first so
				// a large value never wraps into the low clamp
				if (reg_wdata_in > 8'(`SWRS_PERIOD_MAX)) begin
					period_d = `SWRS_PERIOD_MAX;
				end else if (reg_wdata_in[4:0] < `SWRS_PERIOD_MIN) begin
					period_d = `SWRS_PERIOD_MIN;
				end else begin
					period_d = reg_wdata_in[4:0];
				end
			end else if (reg_addr_in == `SWRS_REG_TRIP) begin
				trip_d = reg_wdata_in;
			end else if (reg_addr_in == `SWRS_REG_CLEAR) begin
				status_d = status_q & ~reg_wdata_in[2:0];
			end else if (reg_addr_in == `SWRS_REG_IRQ_EN) begin
				irq_en_d = reg_wdata_in[2:0];
			end
		end
		// a new event wins over a clear in the same cycle
		status_d = status_d | ev;
		if (ev[`SWRS_EV_LV]) begin
			last_d = SWRS_SRC_LV;
		end else if (ev[`SWRS_EV_WDT]) begin
			last_d = SWRS_SRC_WDT;
		end else if (ev[`SWRS_EV_MR]) begin
			last_d = SWRS_SRC_MR;
		end
		if (reg_rd_in) begin
			if (reg_addr_in == `SWRS_REG_CTRL) begin
				rdata_d = {7'h00, wdt_en_q};
			end else if (reg_addr_in == `SWRS_REG_PERIOD) begin
				rdata_d = {3'h0, period_q};
			end else if (reg_addr_in == `SWRS_REG_TRIP) begin
				rdata_d = trip_q;
			end else if (reg_addr_in == `SWRS_REG_STATUS) begin
				rdata_d = {drive_q, 1'b0, last_q, 1'b0, status_q};
			end else if (reg_addr_in == `SWRS_REG_IRQ_EN) begin
				rdata_d = {5'h00, irq_en_q};
			end
		end
		irq_d = |(status_d & irq_en_d);
	end

	// register flops
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			wdt_en_q <= 1'b0;
			period_q <= `SWRS_PERIOD_RST;
			trip_q <= `SWRS_TRIP_RST;
			status_q <= 3'h0;
			irq_en_q <= 3'h0;
			last_q <= SWRS_SRC_NONE;
			rdata_q <= 8'h00;
			irq_q <= 1'b0;
		end else begin
			wdt_en_q <= wdt_en_d;
			period_q <= period_d;
			trip_q <= trip_d;
			status_q <= status_d;
			irq_en_q <= irq_en_d;
			last_q <= last_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end

	// supervisor next state; low supply outranks the other causes
	always_comb begin
		state_d = state_q;
		hold_d = hold_q;
		low_d = supply_low;
		ev = 3'h0;
		// a fresh fall below trip is logged even inside a hold
		ev[`SWRS_EV_LV] = supply_low && !low_q;
		case (state_q)
			SWRS_RUN: begin
				hold_d = 24'h000000;
				if (supply_low) begin
					state_d = SWRS_HOLD;
					ev[`SWRS_EV_LV] = 1'b1;
				end else if (wdt_fire) begin
					state_d = SWRS_HOLD;
					ev[`SWRS_EV_WDT] = 1'b1;
				end else if (mr_fire) begin
					state_d = SWRS_HOLD;
					ev[`SWRS_EV_MR] = 1'b1;
				end
			end
			SWRS_HOLD: begin
				if (supply_low) begin
					hold_d = 24'h000000;
				end else if (hold_q == HOLD_LAST) begin
					state_d = SWRS_RUN;
					hold_d = 24'h000000;
				end else begin
					hold_d = hold_q + 24'h000001;
				end
			end
			default: begin
				state_d = SWRS_HOLD;
				hold_d = 24'h000000;
			end
		endcase
		drive_d = (state_d == SWRS_HOLD);
	end

	// supervisor flops; reset starts in hold as a power-on reset
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			state_q <= SWRS_HOLD;
			hold_q <= 24'h000000;
			drive_q <= 1'b1;
			low_q <= 1'b0;
		end else begin
			state_q <= state_d;
			hold_q <= hold_d;
			drive_q <= drive_d;
			low_q <= low_d;
		end
	end

	// watchdog: prescaler to 100 ms steps, restarted on kick
	always_comb begin
		pre_d = pre_q;
		tick_d = tick_q;
		wdt_fire = 1'b0;
		// disabled or already in reset means no count at all
		if (!wdt_en_q || kick || state_q != SWRS_RUN) begin
			pre_d = 24'h000000;
			tick_d = 5'h00;
		end else if (pre_q == TICK_LAST) begin
			pre_d = 24'h000000;
			if (tick_q + 5'h01 >= period_q) begin
				wdt_fire = 1'b1;
				tick_d = 5'h00;
			end else begin
				tick_d = tick_q + 5'h01;
			end
		end else begin
			pre_d = pre_q + 24'h000001;
		end
	end

	// watchdog flops
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			pre_q <= 24'h000000;
			tick_q <= 5'h00;
		end else begin
			pre_q <= pre_d;
			tick_q <= tick_d;
		end
	end

	// manual reset filter; our own drive masks the sensed level
	always_comb begin
		filt_d = 24'h000000;
		armed_d = armed_q;
		mr_fire = 1'b0;
		// a line still held low after a manual or power-on hold must rise before rearming
		if (rst_line_in) begin
			armed_d = 1'b1;
		end else if (!drive_q && armed_q) begin
			if (filt_q == FILT_LAST) begin
				mr_fire = 1'b1;
				armed_d = 1'b0;
			end else begin
				filt_d = filt_q + 24'h000001;
			end
		end
	end

	// filter flops
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			filt_q <= 24'h000000;
			armed_q <= 1'b0;
		end else begin
			filt_q <= filt_d;
			armed_q <= armed_d;
		end
	end

	// line drive flops; only ever pulls low, pull-up does the rest
	logic line_val_q;
	logic line_oe_n_q;
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			line_val_q <= 1'b0;
			line_oe_n_q <= 1'b0;
		end else begin
			line_val_q <= 1'b0;
			line_oe_n_q <= !drive_d;
		end
	end

	assign rst_line_out = line_val_q;
	assign rst_line_oe_n_out = line_oe_n_q;
	assign reg_rdata_out = rdata_q;
	assign irq_out = irq_q;

endmodule : swrs_top

/* File: testbench/swrs_host.sv */
// host side of the shared reset wire
`timescale 1ns/10ps
module swrs_host (
	input wire logic oe_n_in,
	input wire logic pull_in,
	output logic line_out
);
	// open drain: any low driver wins, else the weak pull-up
	assign line_out = (!oe_n_in || pull_in) ? 1'b0 : 1'b1;
endmodule : swrs_host

/* File: testbench/swrs_properties.sv */
// port checker for the reset supervisor
`timescale 1ns/10ps
module swrs_props #(
	parameter int HOLD_CYC = 20,
	parameter int TICK_CYC = 10,
	parameter int MR_FILT_CYC = 4
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] supply_code_in,
	input wire logic rst_line_in,
	input wire logic rst_line_out,
	input wire logic rst_line_oe_n_out,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out
);
	int hi_cnt;
	int lo_cnt;
	int mr_cnt;
	logic wo_q;
	logic um_q;
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);
	// 255 marks a pull still held from the last event: not armed
	always_ff @(posedge ref_clk_in) begin
		hi_cnt <= (!resetn_in || supply_code_in == 8'h00) ? 0 : hi_cnt + 1;
		lo_cnt <= (!resetn_in || rst_line_oe_n_out) ? 0 : lo_cnt + 1;
		if (!resetn_in || rst_line_in) mr_cnt <= 0;
		else if (!rst_line_oe_n_out) mr_cnt <= 255;
		else if (mr_cnt < 255) mr_cnt <= mr_cnt + 1;
		wo_q <= reg_rd_in && (reg_addr_in == 8'h03 || reg_addr_in == 8'h05);
		um_q <= reg_rd_in && reg_addr_in > 8'h06;
	end
	lv_assert_a: assert property (supply_code_in == 8'h00
		|=> !rst_line_oe_n_out) else $error("no reset on low supply");
	drive_zero_a: assert property (!rst_line_oe_n_out
		|-> rst_line_out == 1'b0) else $error("line driven high");
	hold_min_a: assert property ($rose(rst_line_oe_n_out)
		|-> hi_cnt >= HOLD_CYC - 2) else $error("hold too short");
	hold_max_a: assert property (lo_cnt <= HOLD_CYC + 3)
		else $error("hold too long");
	mr_sense_a: assert property (mr_cnt == MR_FILT_CYC
		|-> ##[0:3] !rst_line_oe_n_out) else $error("manual missed");
	rd_idle_a: assert property (!$past(reg_rd_in)
		|-> reg_rdata_out == 8'h00) else $error("stray read data");
	wo_read_a: assert property (wo_q |-> reg_rdata_out == 8'h00)
		else $error("write-only read nonzero");
	unmapped_a: assert property (um_q |-> reg_rdata_out == 8'h00)
		else $error("unmapped read nonzero");
endmodule : swrs_props

/* File: testbench/swrs_top_tb.sv */
// self-checking bench for the reset supervisor
`timescale 1ns/10ps
module swrs_top_tb;
	localparam int HOLD = 20;
	localparam int FILT = 4;
	logic ref_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] supply_code_in = 8'hFF;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic pull = 1'b0;
	logic rst_line_in;
	logic rst_line_out;
	logic rst_line_oe_n_out;
	logic irq_out;
	logic [7:0] reg_rdata_out;
	logic [7:0] st;
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;
	int i;
	int n;
	always #5 ref_clk_in = ~ref_clk_in;
	swrs_top #(.HOLD_CYC(HOLD), .TICK_CYC(10), .MR_FILT_CYC(FILT)) i_swrs_top (.*);
	swrs_host i_swrs_host (.oe_n_in(rst_line_oe_n_out), .pull_in(pull),
		.line_out(rst_line_in));
	function automatic logic [7:0] rng(int v, int lo, int hi);
		return (v >= lo && v <= hi) ? 8'h01 : 8'h00;
	endfunction : rng
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= w;
		reg_rd_in <= !w;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		#1 st = reg_rdata_out;
	endtask : acc
	// bounded wait on the line enable, cycles counted in t
	task automatic wait_oe(input logic lvl, output int t);
		for (t = 0; rst_line_oe_n_out !== lvl && t < 90; t++)
			@(posedge ref_clk_in) #1;
	endtask : wait_oe
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	// a hang ends in the closing report
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		void'($urandom(32'h59E5));
		repeat (8) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		wait_oe(1'b1, n);
		// defaults: period 0A, trip 80, offset 07 unmapped
		for (i = 0; i < 8; i++) begin
			acc(i[7:0], 8'h00, 1'b0);
			chk(st, i == 1 ? 8'h0A : i == 2 ? 8'h80 : 8'h00);
		end
		acc(8'h02, 8'h40, 1'b1);
		supply_code_in <= 8'h50;
		acc(8'h06, 8'h07, 1'b1);
		chk({7'h00, rst_line_oe_n_out}, 8'h01);
		acc(8'h02, 8'h80, 1'b1);
		supply_code_in <= 8'h00;
		repeat (1 + $urandom % 4) @(posedge ref_clk_in);
		supply_code_in <= 8'h80 | 8'($urandom);
		acc(8'h04, 8'h00, 1'b0);
		chk(st, 8'h91);
		chk({7'h00, irq_out}, 8'h01);
		wait_oe(1'b1, n);
		chk(rng(n, HOLD - 6, HOLD + 2), 8'h01);
		acc(8'h04, 8'h00, 1'b0);
		chk(st, 8'h11);
		acc(8'h05, 8'h07, 1'b1);
		acc(8'h04, 8'h00, 1'b0);
		chk(st & 8'h8F, 8'h00);
		chk({7'h00, irq_out}, 8'h00);
		// period clamps to its range, then 200 ms with random kicks
		acc(8'h01, 8'h00, 1'b1);
		acc(8'h01, 8'h00, 1'b0);
		chk(st, 8'h01);
		acc(8'h01, 8'h1F, 1'b1);
		acc(8'h01, 8'h00, 1'b0);
		chk(st, 8'h1E);
		acc(8'h01, 8'h02, 1'b1);
		acc(8'h00, 8'h01, 1'b1);
		for (i = 0; i < 6; i++) begin
			repeat ($urandom % 12) @(posedge ref_clk_in);
			acc(8'h03, 8'($urandom), 1'b1);
			chk({7'h00, rst_line_oe_n_out}, 8'h01);
		end
		wait_oe(1'b0, n);
		chk(rng(n, 17, 22), 8'h01);
		acc(8'h04, 8'h00, 1'b0);
		chk(st & 8'h37, 8'h22);
		acc(8'h00, 8'h00, 1'b1);
		wait_oe(1'b1, n);
		repeat (60) @(posedge ref_clk_in);
		chk({7'h00, rst_line_oe_n_out}, 8'h01);
		// glitch shorter than the filter, then a real manual press
		for (i = 0; i < 2; i++) begin
			acc(8'h05, 8'h07, 1'b1);
			pull <= 1'b1;
			repeat (i ? FILT + 2 : FILT - 2) @(posedge ref_clk_in);
			pull <= 1'b0;
			#1 chk({7'h00, rst_line_oe_n_out}, 8'(!i));
			acc(8'h04, 8'h00, 1'b0);
			// the last source field keeps the watchdog cause until replaced
			chk(st & 8'h37, i ? 8'h34 : 8'h20);
			wait_oe(1'b1, n);
		end
		summarize();
	end
endmodule : swrs_top_tb
bind swrs_top swrs_props #(.HOLD_CYC(HOLD_CYC), .TICK_CYC(TICK_CYC),
	.MR_FILT_CYC(MR_FILT_CYC)) i_swrs_props (.*);
